// file: mcss_pkg.sv
// shared constants for the clock source and prescaler block
package mcss_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [4:0] OSC_CTRL_OFS = 5'h00;
  localparam logic [4:0] SRC_SEL_OFS = 5'h04;
  localparam logic [4:0] CLK_CTRL_OFS = 5'h08;
  localparam logic [4:0] PRESC_OFS = 5'h0c;
  localparam logic [4:0] TRIM_OFS = 5'h10;
  localparam logic [4:0] IRQ_STAT_OFS = 5'h14;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h18;
  localparam logic [4:0] CFG_OFS = 5'h1c;
  // oscillator control fields
  localparam int XTAL_EN_BIT = 0;
  localparam int PRC_EN_BIT = 1;
  localparam int LPRC_EN_BIT = 2;
  localparam int LOCK_EN_BIT = 3;
  localparam int READY_BIT = 4;
  // interrupt status fields
  localparam int EV_READY_BIT = 0;
  localparam int EV_SWITCH_BIT = 1;
  // configuration byte fields
  localparam int CFG_X2_BIT = 7;
  localparam int CFG_OSC_HI = 6;
  localparam int CFG_OSC_LO = 5;
  localparam int CFG_PRESC_BIT = 3;
  // source selector codes and config byte oscillator codes
  localparam logic [1:0] SRC_XTAL = 2'h0;
  localparam logic [1:0] SRC_PRC = 2'h1;
  localparam logic [1:0] SRC_LPRC = 2'h2;
  localparam logic [1:0] CFG_OSC_XTAL = 2'h3;
  localparam logic [1:0] CFG_OSC_PRC = 2'h2;
  localparam logic [1:0] CFG_OSC_LPRC = 2'h1;
  // reset values and trim clamp limits
  localparam logic [3:0] PRESC_RST = 4'h8;
  localparam logic [3:0] PRESC_FAST = 4'hf;
  localparam logic [7:0] TRIM_RST = 8'h7f;
  localparam logic [7:0] TRIM_MIN = 8'h6c;
  localparam logic [7:0] TRIM_MAX = 8'h92;
  // counts
  localparam logic [3:0] PRESC_TOP = 4'hf;
  localparam logic [6:0] LOCK_PERIODS = 7'h40;
  localparam logic [2:0] MC_LAST = 3'h5;
  localparam int NUM_OSC = 3;
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_HOLD = 2'b01,
    SW_SYNC = 2'b10
  } mcss_sw_t;
endpackage

// file: mcss_top.sv
// clock source selection, prescaler and double-speed control with wishbone registers
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: in double-speed mode a machine cycle lasts six input clock periods, not twelve
// R2: selected source is divided by a programmable factor two to thirty-two
// R3: crystal oscillator is the reset source unless the config byte picks another
// R4: two config byte bits may choose any oscillator as the reset source
// R5: each oscillator has its own enable; crystal enable also gates external input
// R6: precise rc runs standard when lock off, locked when enable and lock set
// R7: hardware sets precise rc ready once the locked loop has settled
// R8: trim register adjusts locked rc below one percent per step, fifteen percent max
// R9: two-bit selector field picks the main clock source
// R10: software enables or bypasses the divide-by-two stage before the core
// R11: software halves or doubles core frequency while running and while idle
// R12: double-speed change takes effect only on a rising edge of halved clock
// R13: output frequency is oscillator frequency divided by 32 minus twice M
// R14: hardware reset loads prescaler with 8h and clears double speed; the code then reloads both from config byte bits 3 and 7
// R15: setting double speed bypasses the prescaler entirely
// R16: source switching takes over at a safe boundary without runt pulses
// R17: software enables the target and waits for ready before selecting it
//////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: register access over Wishbone and the address map.
module mcss_top
  import mcss_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] HW_CONFIG_BYTE,
  input wire logic CRYSTAL_IN,
  input wire logic PRECISE_RC_IN,
  input wire logic LOWPOWER_RC_IN,
  input wire logic IDLE,
  output logic CRYSTAL_OSC_ENABLE,
  output logic PRECISE_RC_ENABLE,
  output logic LOWPOWER_RC_ENABLE,
  output logic RC_LOCK_ENABLE,
  output logic [7:0] RC_FREQ_TRIM,
  output logic CORE_CLK_OUT,
  output logic PERIPH_CLK_OUT,
  output logic MACHINE_CYCLE_STB,
  output logic IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // register file state
  logic cfg_done_r, cfg_done_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [3:0] osc_en_r, osc_en_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic x2_r, x2_nxt;
  logic [3:0] presc_r, presc_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic irq_r, irq_nxt;
  // clock engine state
  logic [NUM_OSC-1:0] prev_r, prev_nxt;
  logic [1:0] act_r, act_nxt;
  mcss_sw_t sw_r, sw_nxt;
  logic half_r, half_nxt;
  logic x2_eff_r, x2_eff_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic div_r, div_nxt;
  logic core_r, core_nxt;
  logic per_r, per_nxt;
  logic [2:0] mc_r, mc_nxt;
  logic mc_stb_r, mc_stb_nxt;
  logic [6:0] lock_cnt_r, lock_cnt_nxt;
  logic ready_r, ready_nxt;

  logic [NUM_OSC-1:0] lvl, rise;
  logic osc_lvl, osc_rise, clk_int, ev_ready, ev_switch;
  logic bus_req, wr_en;
  logic [1:0] cfg_osc;

  //////////////////////////////////////////////////////////////////////////////
  // oscillator gating and edge detection
  // see R5
  assign lvl[0] = CRYSTAL_IN & osc_en_r[XTAL_EN_BIT];
  assign lvl[1] = PRECISE_RC_IN & osc_en_r[PRC_EN_BIT];
  assign lvl[2] = LOWPOWER_RC_IN & osc_en_r[LPRC_EN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
      assign rise[gi] = lvl[gi] & ~prev_r[gi];
    end
  endgenerate

  // see R9
  assign osc_lvl = (act_r < 2'(NUM_OSC)) ? lvl[act_r] : lvl[0];
  assign osc_rise = (act_r < 2'(NUM_OSC)) ? rise[act_r] : rise[0];
  // see R10 see R15
  assign clk_int = x2_eff_r ? osc_lvl : div_r;
  assign cfg_osc = HW_CONFIG_BYTE[CFG_OSC_HI:CFG_OSC_LO];

  //////////////////////////////////////////////////////////////////////////////
  // clock engine
  always_comb begin
    prev_nxt = lvl;
    act_nxt = act_r;
    sw_nxt = sw_r;
    half_nxt = half_r;
    x2_eff_nxt = x2_eff_r;
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    mc_nxt = mc_r;
    mc_stb_nxt = 1'b0;
    lock_cnt_nxt = lock_cnt_r;
    ready_nxt = ready_r;
    ev_switch = 1'b0;
    if (osc_rise) begin
      half_nxt = ~half_r;
      // see R2 see R13
      if (cnt_r >= PRESC_TOP - presc_r) begin
        cnt_nxt = 4'h0;
        div_nxt = ~div_r;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
      // halved clock rises here; osc is high so both paths meet high
      if (!half_r && x2_r != x2_eff_r) begin
        x2_eff_nxt = x2_r; // see R12 see R11
        div_nxt = 1'b1;
        cnt_nxt = 4'h0;
      end
    end
    // see R16
    case (sw_r)
      SW_RUN: begin
        if (sel_r != act_r) begin
          sw_nxt = SW_HOLD;
        end
      end
      SW_HOLD: begin
        if (!clk_int) begin
          act_nxt = sel_r;
          cnt_nxt = 4'h0;
          div_nxt = 1'b0;
          half_nxt = 1'b0;
          sw_nxt = SW_SYNC;
        end
      end
      SW_SYNC: begin
        // output stays low until the new source gives a full high phase
        if (osc_rise) begin
          sw_nxt = SW_RUN;
          ev_switch = 1'b1;
        end
      end
      default: begin
        sw_nxt = SW_RUN;
      end
    endcase
    core_nxt = (sw_r == SW_SYNC) ? 1'b0 : clk_int;
    per_nxt = core_nxt;
    if (IDLE) begin
      core_nxt = 1'b0; // peripherals keep running in idle
    end
    // machine cycle counted in core clock rises; see R1
    if (core_nxt && !core_r) begin
      if (mc_r == MC_LAST) begin
        mc_nxt = 3'h0;
        mc_stb_nxt = 1'b1;
      end else begin
        mc_nxt = mc_r + 3'h1;
      end
    end
    // see R6 see R7
    if (osc_en_r[PRC_EN_BIT] && osc_en_r[LOCK_EN_BIT]) begin
      if (rise[1] && lock_cnt_r != LOCK_PERIODS) begin
        lock_cnt_nxt = lock_cnt_r + 7'h1;
      end
      if (lock_cnt_r == LOCK_PERIODS) begin
        ready_nxt = 1'b1;
      end
    end else begin
      lock_cnt_nxt = 7'h0;
      ready_nxt = 1'b0;
    end
  end

  assign ev_ready = ready_nxt & ~ready_r;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prev_r <= '0;
      act_r <= SRC_XTAL;
      sw_r <= SW_RUN;
      half_r <= 1'b0;
      x2_eff_r <= 1'b0;
      cnt_r <= 4'h0;
      div_r <= 1'b0;
      core_r <= 1'b0;
      per_r <= 1'b0;
      mc_r <= 3'h0;
      mc_stb_r <= 1'b0;
      lock_cnt_r <= 7'h0;
      ready_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      act_r <= act_nxt;
      sw_r <= sw_nxt;
      half_r <= half_nxt;
      x2_eff_r <= x2_eff_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      core_r <= core_nxt;
      per_r <= per_nxt;
      mc_r <= mc_nxt;
      mc_stb_r <= mc_stb_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave and registers
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr_en = bus_req & WB_WE_I & WB_SEL_I[0];

  always_comb begin
    cfg_done_nxt = 1'b1;
    cfg_nxt = cfg_r;
    osc_en_nxt = osc_en_r;
    sel_nxt = sel_r;
    x2_nxt = x2_r;
    presc_nxt = presc_r;
    trim_nxt = trim_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    ack_nxt = bus_req;
    dat_nxt = 32'h0;
    // config byte caught once, on the first edge after reset release
    if (!cfg_done_r) begin
      cfg_nxt = HW_CONFIG_BYTE;
      // see R3 see R4
      case (cfg_osc)
        CFG_OSC_PRC: begin
          sel_nxt = SRC_PRC;
          osc_en_nxt[PRC_EN_BIT] = 1'b1;
        end
        CFG_OSC_LPRC: begin
          sel_nxt = SRC_LPRC;
          osc_en_nxt[LPRC_EN_BIT] = 1'b1;
        end
        default: begin
          sel_nxt = SRC_XTAL;
        end
      endcase
      // a cleared x2 field forces double speed from the start
      x2_nxt = ~HW_CONFIG_BYTE[CFG_X2_BIT];
      presc_nxt = HW_CONFIG_BYTE[CFG_PRESC_BIT] ? PRESC_RST : PRESC_FAST;
    end else if (wr_en) begin
      case (WB_ADR_I)
        OSC_CTRL_OFS: osc_en_nxt = WB_DAT_I[3:0]; // see R5 see R6
        SRC_SEL_OFS: sel_nxt = WB_DAT_I[1:0]; // see R9
        CLK_CTRL_OFS: x2_nxt = WB_DAT_I[0]; // see R11
        PRESC_OFS: presc_nxt = WB_DAT_I[3:0]; // see R13
        TRIM_OFS: begin
          // clamp keeps the locked rc within fifteen percent; see R8
          if (WB_DAT_I[7:0] < TRIM_MIN) begin
            trim_nxt = TRIM_MIN;
          end else if (WB_DAT_I[7:0] > TRIM_MAX) begin
            trim_nxt = TRIM_MAX;
          end else begin
            trim_nxt = WB_DAT_I[7:0];
          end
        end
        IRQ_STAT_OFS: stat_nxt = stat_r & ~WB_DAT_I[1:0];
        IRQ_MASK_OFS: mask_nxt = WB_DAT_I[1:0];
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    if (ev_ready) begin
      stat_nxt[EV_READY_BIT] = 1'b1;
    end
    if (ev_switch) begin
      stat_nxt[EV_SWITCH_BIT] = 1'b1;
    end
    if (bus_req && !WB_WE_I) begin
      case (WB_ADR_I)
        OSC_CTRL_OFS: dat_nxt = {27'h0, ready_r, osc_en_r};
        SRC_SEL_OFS: dat_nxt = {30'h0, sel_r};
        CLK_CTRL_OFS: dat_nxt = {31'h0, x2_r};
        PRESC_OFS: dat_nxt = {28'h0, presc_r};
        TRIM_OFS: dat_nxt = {24'h0, trim_r};
        IRQ_STAT_OFS: dat_nxt = {30'h0, stat_r};
        IRQ_MASK_OFS: dat_nxt = {30'h0, mask_r};
        CFG_OFS: dat_nxt = {24'h0, cfg_r};
        default: dat_nxt = 32'h0;
      endcase
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_done_r <= 1'b0;
      cfg_r <= 8'h0;
      osc_en_r <= 4'h1;
      sel_r <= SRC_XTAL;
      x2_r <= 1'b0; // see R14
      presc_r <= PRESC_RST; // see R14
      trim_r <= TRIM_RST;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      irq_r <= 1'b0;
    end else begin
      cfg_done_r <= cfg_done_nxt;
      cfg_r <= cfg_nxt;
      osc_en_r <= osc_en_nxt;
      sel_r <= sel_nxt;
      x2_r <= x2_nxt;
      presc_r <= presc_nxt;
      trim_r <= trim_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      irq_r <= irq_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign IRQ = irq_r;
  assign CRYSTAL_OSC_ENABLE = osc_en_r[XTAL_EN_BIT];
  assign PRECISE_RC_ENABLE = osc_en_r[PRC_EN_BIT];
  assign LOWPOWER_RC_ENABLE = osc_en_r[LPRC_EN_BIT];
  assign RC_LOCK_ENABLE = osc_en_r[LOCK_EN_BIT];
  assign RC_FREQ_TRIM = trim_r;
  assign CORE_CLK_OUT = core_r;
  assign PERIPH_CLK_OUT = per_r;
  assign MACHINE_CYCLE_STB = mc_stb_r;

endmodule

// file: mcss_properties.sv
// bus, reset and clock output assertions for the clock source block
module mcss_checker
  import mcss_pkg::*;
(
  input logic CORE_CLK,
  input logic RST_B,
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_WE_I,
  input logic [4:0] WB_ADR_I,
  input logic [3:0] WB_SEL_I,
  input logic [31:0] WB_DAT_I,
  input logic [31:0] WB_DAT_O,
  input logic WB_ACK_O,
  input logic IDLE,
  input logic CRYSTAL_OSC_ENABLE,
  input logic PRECISE_RC_ENABLE,
  input logic LOWPOWER_RC_ENABLE,
  input logic RC_LOCK_ENABLE,
  input logic [7:0] RC_FREQ_TRIM,
  input logic CORE_CLK_OUT,
  input logic MACHINE_CYCLE_STB,
  input logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic wt;
  logic [7:0] d_r;
  assign wt = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && !WB_ACK_O;
  always_ff @(posedge CORE_CLK) begin
    d_r <= WB_DAT_I[7:0];
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_ack;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing or too long");
  property p_dat;
    !WB_ACK_O |-> WB_DAT_O == 32'h0;
  endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_rst;
    $rose(RST_B) |-> CRYSTAL_OSC_ENABLE && RC_FREQ_TRIM == TRIM_RST && !IRQ;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_trim;
    RC_FREQ_TRIM inside {[TRIM_MIN:TRIM_MAX]};
  endproperty
  a_trim: assert property (p_trim) else $error("trim out of range");
  property p_trim_wr;
    wt && WB_ADR_I == TRIM_OFS && WB_DAT_I[7:0] inside {[TRIM_MIN:TRIM_MAX]}
      |=> RC_FREQ_TRIM == d_r;
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
  property p_osc_wr;
    wt && WB_ADR_I == OSC_CTRL_OFS |=> {RC_LOCK_ENABLE, LOWPOWER_RC_ENABLE,
      PRECISE_RC_ENABLE, CRYSTAL_OSC_ENABLE} == d_r[3:0];
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("enable write lost");
  property p_idle;
    IDLE [*3] |-> !CORE_CLK_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("core clock runs in idle");
  property p_mc;
    MACHINE_CYCLE_STB |=> !MACHINE_CYCLE_STB [*8];
  endproperty
  a_mc: assert property (p_mc) else $error("machine cycle too short");
  c_rd: cover property (WB_ACK_O && !WB_WE_I);
  c_irq: cover property ($rose(IRQ));
  c_mc: cover property (MACHINE_CYCLE_STB);
endmodule
bind mcss_top mcss_checker mcss_checker_i (.*);

// file: testbench.sv
// directed bench for the clock source block
module testbench
  import mcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 0, RST_B = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, IDLE = 0;
  logic CRYSTAL_IN = 0, PRECISE_RC_IN = 0, LOWPOWER_RC_IN = 0;
  logic [4:0] WB_ADR_I = 5'h0;
  logic [3:0] WB_SEL_I = 4'h1;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
  logic [7:0] HW_CONFIG_BYTE = 8'h88, RC_FREQ_TRIM;
  logic WB_ACK_O, CRYSTAL_OSC_ENABLE, PRECISE_RC_ENABLE, LOWPOWER_RC_ENABLE, RC_LOCK_ENABLE;
  logic CORE_CLK_OUT, PERIPH_CLK_OUT, MACHINE_CYCLE_STB, IRQ;
  int errors = 0, n_checks = 0, k = 0;
  mcss_top mcss_top_i (.*);
  initial begin
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  // oscillators of 4, 6 and 10 core periods, all slower than half the core clock
  always @(posedge CORE_CLK) begin
    k <= k + 1;
    CRYSTAL_IN <= (k % 4) < 2;
    PRECISE_RC_IN <= (k % 6) < 3;
    LOWPOWER_RC_IN <= (k % 10) < 5;
  end
  //////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task xf(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int i;
    @(posedge CORE_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h0, d};
    for (i = 0; i < 9; i++) begin
      @(posedge CORE_CLK);
      if (WB_ACK_O === 1'b1) break;
    end
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (i == 9) begin
      chk("ack", 32'h1, 32'h0);
      conclude;
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    xf(1'b1, a, d, q);
  endtask
  task rc(input logic [4:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    xf(1'b0, a, 8'h0, q);
    chk(n, e, q);
  endtask
  task pl(input logic [4:0] a, input int b, input string n);
    int i;
    logic [31:0] q;
    for (i = 0; i < 300; i++) begin
      xf(1'b0, a, 8'h0, q);
      if (q[b] === 1'b1) break;
    end
    chk(n, 32'h1, {31'h0, q[b]});
    if (i == 300) conclude;
  endtask
  // cycles between two rises of the peripheral clock or the cycle strobe
  task per(input logic s, input int e, input string n);
    int i, p;
    logic l, c;
    p = 0;
    l = 1'b1;
    for (i = 0; i < 900; i++) begin
      @(posedge CORE_CLK);
      c = s ? MACHINE_CYCLE_STB : PERIPH_CLK_OUT;
      if (c && !l && p > 0) break;
      if (c && !l) p = 1;
      else if (p > 0) p++;
      l = c;
    end
    chk(n, e, p);
    if (i == 900) begin
      errors++;
      conclude;
    end
  endtask
  task rst(input logic [7:0] c);
    RST_B <= 1'b0;
    HW_CONFIG_BYTE <= c;
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_rst;
    rc(OSC_CTRL_OFS, 32'h1, "osc ctrl");
    rc(SRC_SEL_OFS, 32'h0, "source");
    rc(CLK_CTRL_OFS, 32'h0, "x2");
    rc(PRESC_OFS, {28'h0, PRESC_RST}, "prescaler");
    rc(TRIM_OFS, {24'h0, TRIM_RST}, "trim");
    per(1'b0, 64, "div16");
    $display("t_rst done");
  endtask
  task t_div;
    logic [3:0] m[3] = '{4'hf, 4'he, 4'h0};
    foreach (m[j]) begin
      wr(PRESC_OFS, {4'h0, m[j]});
      repeat (140) @(posedge CORE_CLK);
      per(1'b0, 4 * (32 - 2 * m[j]), "prescaled");
    end
    wr(PRESC_OFS, 8'h0f);
    repeat (20) @(posedge CORE_CLK);
    per(1'b1, 48, "cycle std");
    $display("t_div done");
  endtask
  task t_x2;
    int i, hi;
    hi = 0;
    wr(CLK_CTRL_OFS, 8'h01);
    repeat (20) @(posedge CORE_CLK);
    per(1'b0, 4, "x2 clock");
    per(1'b1, 24, "cycle x2");
    IDLE <= 1'b1;
    for (i = 0; i < 24; i++) begin
      @(posedge CORE_CLK);
      if (i > 3 && CORE_CLK_OUT !== 1'b0) hi++;
    end
    chk("idle core", 32'h0, hi);
    per(1'b0, 4, "idle periph");
    IDLE <= 1'b0;
    wr(CLK_CTRL_OFS, 8'h00);
    repeat (20) @(posedge CORE_CLK);
    per(1'b0, 8, "halved");
    $display("t_x2 done");
  endtask
  task t_trim;
    wr(TRIM_OFS, 8'hff);
    rc(TRIM_OFS, {24'h0, TRIM_MAX}, "trim hi");
    wr(TRIM_OFS, 8'h00);
    rc(TRIM_OFS, {24'h0, TRIM_MIN}, "trim lo");
    wr(TRIM_OFS, 8'h80);
    rc(TRIM_OFS, 32'h80, "trim mid");
    $display("t_trim done");
  endtask
  task t_irq;
    wr(OSC_CTRL_OFS, 8'h0b);
    pl(OSC_CTRL_OFS, READY_BIT, "ready");
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(IRQ_MASK_OFS, 8'h01);
    repeat (2) @(posedge CORE_CLK);
    chk("irq raised", 32'h1, {31'h0, IRQ});
    wr(IRQ_STAT_OFS, 8'h01);
    repeat (2) @(posedge CORE_CLK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    $display("t_irq done");
  endtask
  task t_sw;
    wr(SRC_SEL_OFS, {6'h0, SRC_PRC});
    pl(IRQ_STAT_OFS, EV_SWITCH_BIT, "switched");
    repeat (20) @(posedge CORE_CLK);
    per(1'b0, 12, "rc clock");
    // low-power source is never picked at reset here, so switch to it once
    wr(IRQ_STAT_OFS, 8'h02);
    wr(OSC_CTRL_OFS, 8'h0f);
    wr(SRC_SEL_OFS, {6'h0, SRC_LPRC});
    pl(IRQ_STAT_OFS, EV_SWITCH_BIT, "switched lp");
    repeat (30) @(posedge CORE_CLK);
    per(1'b0, 20, "lp clock");
    $display("t_sw done");
  endtask
  task t_cfg;
    rc(SRC_SEL_OFS, {30'h0, SRC_PRC}, "cfg source");
    rc(CLK_CTRL_OFS, 32'h1, "cfg x2");
    chk("cfg enable", 32'h1, {31'h0, PRECISE_RC_ENABLE});
    // source switch and x2 takeover settle over a few rc periods after reset
    repeat (40) @(posedge CORE_CLK);
    per(1'b0, 6, "cfg clock");
    $display("t_cfg done");
  endtask
  initial begin
    rst(8'h88);
    t_rst;
    t_div;
    t_x2;
    t_trim;
    t_irq;
    t_sw;
    rst(8'h40);
    t_cfg;
    conclude;
  end
endmodule
